/* mrf_map.svh */
// Purpose: register offsets, field positions, reset values and timing
// Assumes: register port uses the printed offsets as addresses
// Notes: definitions only
`ifndef MRF_MAP_SVH
`define MRF_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define MRF_TX_OFS 8'h23
`define MRF_RX_OFS 8'h24
`define MRF_THR_OFS 8'h25
`define MRF_JAB_OFS 8'h27

// ----------------------------------------------------------------------
// fifo port field positions
// ----------------------------------------------------------------------
`define MRF_LVL_HI 15
`define MRF_LVL_LO 12
`define MRF_FLAG_BIT 11
`define MRF_FULL_BIT 10
`define MRF_EMPTY_BIT 9
`define MRF_PAR_BIT 8
`define MRF_RXTHR_HI 7
`define MRF_RXTHR_LO 4
`define MRF_TXTHR_HI 3
`define MRF_TXTHR_LO 0

// ----------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------
`define MRF_RX_RESET 16'h0200
`define MRF_THR_RESET 16'h0000
`define MRF_JAB_RESET 16'h0000
`define MRF_FIFO_DEPTH 15

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MRF_STEP_NS 2048000
`define MRF_CLK_NS 100

`endif

/* mrf_pkg.sv */
// Purpose: shared types of the modem fifo port block
// Assumes: nothing beyond the map header
// Notes: talk time-out sequencer states
package mrf_pkg;

  // ----------------------------------------------------------------------
  // talk time-out states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MRF_JAB_IDLE = 2'b00,
    MRF_JAB_RUN = 2'b01,
    MRF_JAB_TRIP = 2'b10
  } mrf_jab_type;

endpackage

/* mrf_top.sv */
// Purpose: receive/transmit fifo ports, alarm thresholds, talk time-out
// Assumes: host register port and modem side run on mclk
// Notes: reading the receive port pops one entry
//
// Summary of operation
// - receive port register is read only; writes change nothing
// - bits 15..12 give receive fill count, zero after reset
// - bit 11 set when fill count reached a nonzero alarm threshold
// - bit 10 set while receive fifo holds its maximum entries
// - bit 9 set while receive fifo empty; reset value 0x0200
// - bit 8 is odd parity over the presented data byte
// - bits 7..0 are the received byte from the demodulator
// - bits 7..4 of threshold register: receive threshold, read-write
// - bits 3..0: transmit threshold, read-write; bits 15..8 read zero
// - talk time-out is 8-bit value times 2.048 ms, reset zero
// - receive threshold event masked from irq while mask bit set
// - transmit port register: same status, bits 8..0 read zero; host writes carry data and parity
`timescale 1ns/1ps
`include "mrf_map.svh"

module mrf_top
  import mrf_pkg::*;
#(
  parameter int DEPTH = `MRF_FIFO_DEPTH,
  parameter int STEP_CYC = `MRF_STEP_NS / `MRF_CLK_NS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_parity,
  input wire logic tx_ready,
  input wire logic tx_active,
  output logic jabber_trip,
  input wire logic rx_level_mask,
  output logic rx_threshold_event,
  output logic rx_level_irq
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int STEPW = $clog2(STEP_CYC + 1);
  localparam logic [3:0] FULL_CNT = 4'(DEPTH);

  // ----------------------------------------------------------------------
  // state of the block
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][7:0] rmem;
    logic [PW-1:0] rwp;
    logic [PW-1:0] rrp;
    logic [3:0] rcnt;
    logic [DEPTH-1:0][8:0] tmem;
    logic [PW-1:0] twp;
    logic [PW-1:0] trp;
    logic [3:0] tcnt;
    logic [3:0] rthr;
    logic [3:0] tthr;
    logic [7:0] tout;
    mrf_jab_type jab;
    logic [STEPW-1:0] step;
    logic [7:0] units;
    logic [15:0] rdata;
    logic rvalid;
  } mrf_state_type;

  mrf_state_type s_q;
  mrf_state_type s_d;
  logic rx_push;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic [7:0] rx_head;
  logic rx_flag;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // pointer step with wrap at the fifo depth
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // threshold compare; zero threshold means not programmed
  function automatic logic lvl_hit(input logic [3:0] cnt,
                                   input logic [3:0] thr);
    lvl_hit = (thr != 4'h0) && (cnt >= thr);
  endfunction

  // common status half of both fifo ports
  function automatic logic [15:0] status(input logic [3:0] cnt,
                                         input logic [3:0] thr);
    logic [15:0] v;
    v = 16'h0000;
    v[`MRF_LVL_HI:`MRF_LVL_LO] = cnt;
    v[`MRF_FLAG_BIT] = lvl_hit(cnt, thr);
    v[`MRF_FULL_BIT] = (cnt == FULL_CNT);
    v[`MRF_EMPTY_BIT] = (cnt == 4'h0);
    status = v;
  endfunction

  // ----------------------------------------------------------------------
  // handshakes and strobes
  // ----------------------------------------------------------------------
  // fifo flow control toward demodulator and modulator
  assign rx_ready = (s_q.rcnt != FULL_CNT);
  assign rx_push = rx_valid && rx_ready;
  assign rx_pop = reg_rd && (reg_addr == `MRF_RX_OFS) && (s_q.rcnt != 4'h0);
  assign tx_push = reg_wr && (reg_addr == `MRF_TX_OFS) &&
                   (s_q.tcnt != FULL_CNT);
  assign tx_valid = (s_q.tcnt != 4'h0);
  assign tx_pop = tx_valid && tx_ready;
  assign rx_head = s_q.rmem[s_q.rrp];
  assign tx_data = s_q.tmem[s_q.trp][7:0];
  assign tx_parity = s_q.tmem[s_q.trp][8];
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign jabber_trip = (s_q.jab == MRF_JAB_TRIP);
  assign rx_flag = lvl_hit(s_q.rcnt, s_q.rthr);
  assign rx_threshold_event = rx_flag;
  assign rx_level_irq = rx_flag && !rx_level_mask;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rvalid = reg_rd;
    // receive fifo; host writes to its port are never looked at
    if (rx_push) begin
      s_d.rmem[s_q.rwp] = rx_data;
      s_d.rwp = ptr_inc(s_q.rwp);
    end
    if (rx_pop) begin
      s_d.rrp = ptr_inc(s_q.rrp);
    end
    // count moves only by push and pop
    if (rx_push && !rx_pop) begin
      s_d.rcnt = s_q.rcnt + 4'h1;
    end else if (rx_pop && !rx_push) begin
      s_d.rcnt = s_q.rcnt - 4'h1;
    end
    // transmit fifo fed by host writes
    if (tx_push) begin
      s_d.tmem[s_q.twp] = reg_wdata[`MRF_PAR_BIT:0];
      s_d.twp = ptr_inc(s_q.twp);
    end
    if (tx_pop) begin
      s_d.trp = ptr_inc(s_q.trp);
    end
    if (tx_push && !tx_pop) begin
      s_d.tcnt = s_q.tcnt + 4'h1;
    end else if (tx_pop && !tx_push) begin
      s_d.tcnt = s_q.tcnt - 4'h1;
    end
    if (reg_wr && (reg_addr == `MRF_THR_OFS)) begin
      s_d.rthr = reg_wdata[`MRF_RXTHR_HI:`MRF_RXTHR_LO];
      s_d.tthr = reg_wdata[`MRF_TXTHR_HI:`MRF_TXTHR_LO];
    end
    if (reg_wr && (reg_addr == `MRF_JAB_OFS)) begin
      s_d.tout = reg_wdata[7:0];
    end
    // read mux, answer one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `MRF_RX_OFS: begin
          s_d.rdata = status(s_q.rcnt, s_q.rthr);
          // byte with odd parity
          // empty port keeps byte and parity at zero, as after reset
          if (s_q.rcnt != 4'h0) begin
            s_d.rdata[7:0] = rx_head;
            s_d.rdata[`MRF_PAR_BIT] = ~^rx_head;
          end
        end
        `MRF_TX_OFS: begin
          s_d.rdata = status(s_q.tcnt, s_q.tthr);
        end
        `MRF_THR_OFS: begin
          s_d.rdata = {8'h00, s_q.rthr, s_q.tthr};
        end
        `MRF_JAB_OFS: begin
          s_d.rdata = {8'h00, s_q.tout};
        end
        default: begin
          s_d.rdata = 16'h0000;
        end
      endcase
    end
    // count 2.048 ms steps while transmitting
    case (s_q.jab)
      MRF_JAB_IDLE: begin
        s_d.step = '0;
        s_d.units = 8'h00;
        if (tx_active && (s_q.tout != 8'h00)) begin
          s_d.jab = MRF_JAB_RUN;
        end
      end
      MRF_JAB_RUN: begin
        if (!tx_active) begin
          s_d.jab = MRF_JAB_IDLE;
        end else if (s_q.step == STEPW'(STEP_CYC - 1)) begin
          s_d.step = '0;
          s_d.units = s_q.units + 8'h01;
          if ((s_q.units + 8'h01) == s_q.tout) begin
            s_d.jab = MRF_JAB_TRIP;
          end
        end else begin
          s_d.step = s_q.step + 1'b1;
        end
      end
      MRF_JAB_TRIP: begin
        if (!tx_active) begin
          s_d.jab = MRF_JAB_IDLE;
        end
      end
      default: begin
        s_d.jab = MRF_JAB_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.rthr <= 4'(`MRF_THR_RESET >> `MRF_RXTHR_LO);
      s_q.tthr <= 4'(`MRF_THR_RESET);
      s_q.tout <= 8'(`MRF_JAB_RESET);
      s_q.jab <= MRF_JAB_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_rx_write_ignored: assert property (
    reg_wr && (reg_addr == `MRF_RX_OFS) && !rx_push && !rx_pop
    |=> $stable(s_q.rcnt) && $stable(s_q.rrp))
    else $error("write to receive port changed fifo");

  a_rx_level_field: assert property (
    reg_rd && (reg_addr == `MRF_RX_OFS)
    |=> reg_rvalid && (reg_rdata[15:12] == $past(s_q.rcnt)))
    else $error("receive level field wrong");

  a_rx_flag_field: assert property (
    reg_rd && (reg_addr == `MRF_RX_OFS)
    |=> reg_rdata[11] == ($past(s_q.rthr) != 4'h0 &&
                          $past(s_q.rcnt) >= $past(s_q.rthr)))
    else $error("receive threshold flag wrong");

  a_rx_full_stall: assert property (
    (s_q.rcnt == FULL_CNT) && !rx_pop |=> (s_q.rcnt == FULL_CNT) && !rx_ready)
    else $error("full receive fifo accepted data");

  a_rx_empty_flag: assert property (
    reg_rd && (reg_addr == `MRF_RX_OFS) && (s_q.rcnt == 4'h0)
    |=> reg_rdata[9] && !reg_rdata[10] && (reg_rdata[15:12] == 4'h0))
    else $error("empty flag not shown");

  a_rx_odd_parity: assert property (
    reg_rd && (reg_addr == `MRF_RX_OFS) && (s_q.rcnt != 4'h0)
    |=> ^reg_rdata[8:0])
    else $error("receive parity not odd");

  a_rx_data_order: assert property (
    rx_push && (s_q.rcnt == 4'h0) ##1 reg_rd && (reg_addr == `MRF_RX_OFS)
    |=> reg_rdata[7:0] == $past(rx_data, 2))
    else $error("receive byte lost or reordered");

  a_thr_write: assert property (
    reg_wr && (reg_addr == `MRF_THR_OFS)
    ##1 !(reg_wr && (reg_addr == `MRF_THR_OFS))
    ##1 reg_rd && (reg_addr == `MRF_THR_OFS) && !reg_wr
    |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 3)})
    else $error("threshold register readback wrong");

  a_irq_masked: assert property (
    rx_level_mask |-> !rx_level_irq)
    else $error("masked threshold event reached irq");

  a_jab_trip_time: assert property (
    $rose(jabber_trip) |-> (s_q.units == s_q.tout) && $past(tx_active))
    else $error("talk time-out tripped early or late");

  a_tx_push_count: assert property (
    tx_push && !tx_pop |=> s_q.tcnt == $past(s_q.tcnt) + 4'h1)
    else $error("transmit write not counted");

endmodule

/* mrf_modem_model.sv */
// Purpose: modem side of the fifo port block, byte source and sink
// Assumes: same clock as the block, handshake sampled on rising edge
// Notes: source holds each byte until taken, inverts data when idle
`timescale 1ns/1ps

module mrf_modem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] base,
  input wire logic [4:0] n,
  input wire logic snk_en,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_parity,
  output logic tx_ready,
  output logic [8:0] got,
  output logic [4:0] got_cnt
);
  // --------------------------------------------------------------------
  // byte source and stallable sink
  // --------------------------------------------------------------------
  logic [4:0] left_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      left_q <= 5'h00;
      rx_valid <= 1'b0;
      rx_data <= 8'h5a;
      tx_ready <= 1'b0;
      got <= 9'h000;
      got_cnt <= 5'h00;
    end else begin
      tx_ready <= snk_en;
      if (tx_valid && tx_ready) begin
        got <= {tx_parity, tx_data};
        got_cnt <= got_cnt + 5'h01;
      end
      if (load) begin
        left_q <= n;
        rx_valid <= (n != 5'h00);
        rx_data <= base;
      end else if (rx_valid && rx_ready) begin
        left_q <= left_q - 5'h01;
        rx_valid <= (left_q > 5'h01);
        // released line shows the inverse, not the last byte
        rx_data <= (left_q > 5'h01) ? rx_data + 8'h01 : ~rx_data;
      end
    end
  end
endmodule

/* tb_top.sv */
// Purpose: self-checking bench of the modem fifo port block
// Assumes: short time-out step of 4 cycles
// Notes: expectations come from field layout and odd parity
`timescale 1ns/1ps
`include "mrf_map.svh"

module tb_top;
  logic mclk, rst, reg_wr, reg_rd, tx_active, rx_level_mask, load, snk_en;
  logic [7:0] reg_addr, base, rx_data, tx_data;
  logic [15:0] reg_wdata, reg_rdata, rd_v;
  logic reg_rvalid, rx_valid, rx_ready, tx_valid, tx_parity, tx_ready;
  logic jabber_trip, rx_threshold_event, rx_level_irq;
  logic [4:0] n, got_cnt;
  logic [8:0] got;
  int failures, checked;

  // --------------------------------------------------------------------
  // block and modem model
  // --------------------------------------------------------------------
  mrf_top #(.STEP_CYC(4)) i_dut (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_parity(tx_parity),
    .tx_ready(tx_ready), .tx_active(tx_active), .jabber_trip(jabber_trip),
    .rx_level_mask(rx_level_mask), .rx_threshold_event(rx_threshold_event),
    .rx_level_irq(rx_level_irq));

  mrf_modem_model i_modem (.mclk(mclk), .rst(rst), .load(load), .base(base),
    .n(n), .snk_en(snk_en), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_parity(tx_parity), .tx_ready(tx_ready), .got(got),
    .got_cnt(got_cnt));

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic step;
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    step;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    step;
    reg_addr = a;
    reg_rd = 1'b1;
    step;
    reg_rd = 1'b0;
    chk("rvalid", {15'h0, reg_rvalid}, 16'h0001);
    rd_v = reg_rdata;
  endtask

  function automatic logic par(input logic [7:0] b);
    return ~^b;
  endfunction

  task automatic final_report;
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_reset;
    rd(`MRF_RX_OFS); chk("rx reset", rd_v, `MRF_RX_RESET);
    rd(`MRF_THR_OFS); chk("thr reset", rd_v, `MRF_THR_RESET);
    rd(`MRF_JAB_OFS); chk("jab reset", rd_v, `MRF_JAB_RESET);
    rd(8'h26); chk("unmapped", rd_v, 16'h0000);
    wr(`MRF_RX_OFS, 16'hffff);
    rd(`MRF_RX_OFS); chk("rx ro", rd_v, 16'h0200);
  endtask

  task automatic t_cfg;
    wr(`MRF_THR_OFS, 16'hffa5);
    rd(`MRF_THR_OFS); chk("thr rw", rd_v, 16'h00a5);
    wr(`MRF_JAB_OFS, 16'h1234);
    rd(`MRF_JAB_OFS); chk("jab rw", rd_v, 16'h0034);
  endtask

  task automatic t_rx;
    logic [7:0] b;
    logic [4:0] c;
    logic [15:0] e;
    wr(`MRF_THR_OFS, 16'h0030);
    base = 8'h10;
    n = 5'd15;
    step;
    load = 1'b1;
    step;
    load = 1'b0;
    repeat (20) step;
    chk("rx full", {15'h0, rx_ready}, 16'h0000);
    chk("irq", {15'h0, rx_level_irq}, 16'h0001);
    rx_level_mask = 1'b1;
    #1 chk("irq mask", {15'h0, rx_level_irq}, 16'h0000);
    rx_level_mask = 1'b0;
    for (int i = 0; i < 15; i++) begin
      c = 5'd15 - 5'(i);
      b = 8'h10 + 8'(i);
      chk("event", {15'h0, rx_threshold_event}, {15'h0, c >= 5'd3});
      rd(`MRF_RX_OFS);
      e = {c[3:0], c >= 5'd3, i == 0, 1'b0, par(b), b};
      chk("rx pop", rd_v, e);
    end
    rd(`MRF_RX_OFS); chk("rx empty", {9'h0, rd_v[15:9]}, 16'h0001);
    // single byte read on the cycle right after it lands
    base = 8'h6b;
    n = 5'd1;
    step;
    load = 1'b1;
    step;
    load = 1'b0;
    rd(`MRF_RX_OFS);
    e = {4'h1, 1'b0, 1'b0, 1'b0, par(8'h6b), 8'h6b};
    chk("rx first", rd_v, e);
  endtask

  task automatic t_tx;
    logic [7:0] b;
    wr(`MRF_THR_OFS, 16'h0032);
    for (int i = 0; i < 3; i++) begin
      b = 8'ha0 + 8'(i);
      wr(`MRF_TX_OFS, {7'h0, par(b), b});
    end
    rd(`MRF_TX_OFS); chk("tx status", rd_v, 16'h3800);
    snk_en = 1'b1;
    repeat (10) step;
    chk("tx count", {11'h0, got_cnt}, 16'h0003);
    chk("tx last", {7'h0, got}, {7'h0, par(8'ha2), 8'ha2});
    chk("tx empty", {15'h0, tx_valid}, 16'h0000);
    snk_en = 1'b0;
  endtask

  task automatic t_jab;
    wr(`MRF_JAB_OFS, 16'h0002);
    step;
    tx_active = 1'b1;
    repeat (8) step;
    chk("trip early", {15'h0, jabber_trip}, 16'h0000);
    step;
    chk("trip", {15'h0, jabber_trip}, 16'h0001);
    tx_active = 1'b0;
    repeat (2) step;
    chk("trip clear", {15'h0, jabber_trip}, 16'h0000);
  endtask

  // --------------------------------------------------------------------
  // clock, main sequence, watchdog
  // --------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 16'h0000; tx_active = 1'b0; rx_level_mask = 1'b0;
    load = 1'b0; snk_en = 1'b0; base = 8'h00; n = 5'h00;
    failures = 0; checked = 0;
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    t_reset;
    t_cfg;
    t_rx;
    t_tx;
    t_jab;
    final_report;
  end

  initial begin
    #3000000;
    failures++;
    final_report;
  end
endmodule
